/* rtl/mflm_pkg.sv */
// Shared constants of the metering front end line monitor
package mflm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock
    localparam int CLK_HZ = 25_000_000;
    localparam logic [1:0] SAMP_PH_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_KV = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0C;
    localparam logic [7:0] ADR_LIVE = 8'h10;
    localparam logic [7:0] ADR_VOLT = 8'h14;
    localparam logic [7:0] ADR_CURR = 8'h18;
    localparam logic [7:0] ADR_PER = 8'h1C;

    // Control fields
    localparam int CTRL_W = 4;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_XG_BIT = 2;
    localparam int CTRL_DUAL_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Voltage calibrator, 1.0 = 0x400, range 0.875 .. 1.000
    localparam int KV_W = 11;
    localparam logic [10:0] KV_MIN = 11'h380;
    localparam logic [10:0] KV_MAX = 11'h400;
    localparam logic [10:0] KV_RST = 11'h400;

    // Interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_BFR_SET = 0;
    localparam int IRQ_BFR_CLR = 1;
    localparam int IRQ_RESULT = 2;
    localparam int IRQ_PULSE = 3;
    localparam logic [3:0] MASK_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Decimation
    localparam int OSR_LOG = 9;
    localparam int VOLT_W = 11;
    localparam int CURR_W = 16;
    localparam int VOLT_PRE_SHL = 0;
    localparam int CURR_PRE_SHL = 7;
    localparam logic [9:0] GAIN_NUM = 10'h101;
    localparam int GAIN_V_SHR = 8;
    localparam int GAIN_I_SHR = 9;
    localparam int DC_SHIFT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Current gain codes and sensor selects
    localparam logic [5:0] GAIN_8 = 6'h08;
    localparam logic [5:0] GAIN_16 = 6'h10;
    localparam logic [5:0] GAIN_24 = 6'h18;
    localparam logic [5:0] GAIN_32 = 6'h20;
    localparam logic [1:0] SEL_CT = 2'h2;
    localparam logic [1:0] SEL_SHUNT = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Period monitor, counts of system clock cycles
    localparam int PER_W = 18;
    localparam int PER_LONG_CYC = 2 ** 17;
    localparam int PER_SHORT_CYC = 2 ** 15;
    localparam logic [1:0] SHORT_REPEAT = 2'h3;

    // Peak code * Kv(x1024) at the RMS error threshold
    localparam logic [21:0] RMS_ON_CT = 22'h005C2E;
    localparam logic [21:0] RMS_ON_ROGO = 22'h005C66;

    ////////////////////////////////////////////////////////////////////////
    // Energy pulses and channel multiplexing
    localparam int MUX_LEN = 64;
    localparam logic [31:0] PULSE_THR = 32'h0100_0000;
    localparam logic [7:0] PULSE_CYC = 8'hFF;

endpackage

/* rtl/mflm_decim.sv */
// Sigma-delta decimator with fixed gain and DC offset removal
`timescale 1ns/1ps
module mflm_decim
    import mflm_pkg::*;
#(
    parameter int OUT_W = 11,
    parameter int PRE_SHL = 0,
    parameter int GAIN_SHR = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic samp_en_i,
    input wire logic bit_i,
    output logic signed [OUT_W-1:0] res_o,
    output logic valid_o
);

    localparam int RAW_W = OSR_LOG + 2;
    localparam int PW = RAW_W + PRE_SHL + 11;
    localparam int DW = PW + DC_SHIFT;
    localparam logic signed [PW-1:0] OUT_MAX = PW'((2 ** (OUT_W - 1)) - 1);
    localparam logic signed [PW-1:0] OUT_MIN = -OUT_MAX - PW'(1);

    logic [OSR_LOG-1:0] cnt_r;
    logic signed [RAW_W-1:0] acc_r;
    logic signed [RAW_W-1:0] acc_nxt;
    logic signed [RAW_W-1:0] raw_r;
    logic raw_v_r;
    logic signed [PW-1:0] scaled;
    logic signed [PW-1:0] diff;
    logic signed [DW-1:0] dc_r;

    ////////////////////////////////////////////////////////////////////////
    // Integrate and dump
    always_comb begin
        acc_nxt = bit_i ? acc_r + RAW_W'(1) : acc_r - RAW_W'(1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            acc_r <= '0;
            raw_r <= '0;
            raw_v_r <= 1'b0;
        end else begin
            raw_v_r <= 1'b0;
            if (samp_en_i) begin
                cnt_r <= cnt_r + OSR_LOG'(1);
                if (&cnt_r) begin
                    raw_r <= acc_nxt;
                    raw_v_r <= 1'b1;
                    acc_r <= '0;
                end else begin
                    acc_r <= acc_nxt;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed gain, DC removal, saturation
    always_comb begin
        scaled = ((PW'(raw_r) <<< PRE_SHL) * $signed({1'b0, GAIN_NUM})) >>> GAIN_SHR;
        diff = scaled - PW'(dc_r >>> DC_SHIFT);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dc_r <= '0;
            res_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= raw_v_r;
            if (raw_v_r) begin
                dc_r <= dc_r + DW'(scaled) - (dc_r >>> DC_SHIFT);
                if (diff > OUT_MAX) begin
                    res_o <= OUT_MAX[OUT_W-1:0];
                end else if (diff < OUT_MIN) begin
                    res_o <= OUT_MIN[OUT_W-1:0];
                end else begin
                    res_o <= diff[OUT_W-1:0];
                end
            end
        end
    end

endmodule

/* rtl/mflm_top.sv */
// Metering front end: decimation, gain decode, line period and level monitor
//
// Contract
// - Single channel: gain 8/16/24/32 from select and extra bit; CT 8, shunt 32.
// - Dual channel: select 3 gives primary 8, secondary 32; else equal gains.
// - Dual channel: primary and secondary current share one path, alternately.
// - Bitstreams are sampled at a quarter of the system clock.
// - Decimation gain is 1.004 for voltage and 64.25 for current.
// - Results are 11 bits for voltage and 16 bits for current.
// - DC offset is removed automatically from both channels.
// - Peak pulse per positive voltage peak; count clocks between its trailing edges.
// - Range error at once when period exceeds long limit or counting stalls.
// - Range error for too short periods only after three in a row.
// - Range error when voltage RMS falls below the sensor-dependent threshold.
// - RMS-caused error clears only above twice the threshold.
// - During range error: no power accumulation, stepper and pulse outputs low.
// - Voltage calibrator covers 0.875 to 1.000.
`timescale 1ns/1ps
module mflm_top
    import mflm_pkg::*;
#(
    parameter int PER_LONG = PER_LONG_CYC,
    parameter int PER_SHORT = PER_SHORT_CYC,
    parameter int MUX_OUTPUTS = MUX_LEN
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sd_volt_i,
    input wire logic sd_curr_i,
    output logic samp_clk_o,
    output logic cur_sel_o,
    output logic [5:0] pga_gain_o,
    output logic base_freq_range_error_o,
    output logic stepper_drive_pos_o,
    output logic stepper_drive_neg_o,
    output logic pulse_o,
    output logic irq_o
);

    logic [1:0] volt_sync_r;
    logic [1:0] curr_sync_r;
    logic [1:0] ph_r;
    logic samp_en_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [KV_W-1:0] kv_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] mask_r;
    logic [IRQ_W-1:0] ev;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic wr_stb;
    logic signed [VOLT_W-1:0] volt_res;
    logic signed [CURR_W-1:0] curr_res;
    logic volt_v;
    logic curr_v;
    logic [1:0] gsel;
    logic xg;
    logic dual;
    logic [5:0] gain_nxt;
    logic [$clog2(MUX_OUTPUTS)-1:0] mux_cnt_r;
    logic settle_r;
    logic signed [VOLT_W-1:0] vprev_r;
    logic rising_r;
    logic peak_r;
    logic peak_q_r;
    logic trail;
    logic [PER_W-1:0] per_cnt_r;
    logic [PER_W-1:0] per_last_r;
    logic [1:0] short_run_r;
    logic low_err_r;
    logic high_err_r;
    logic rms_err_r;
    logic [VOLT_W-2:0] vpk_run_r;
    logic [VOLT_W-2:0] vpk_r;
    logic [21:0] rms_prod;
    logic [21:0] rms_thr;
    logic bfr_nxt;
    logic bfr_q_r;
    logic signed [31:0] pacc_r;
    logic signed [31:0] pacc_sum;
    logic [7:0] pulse_cnt_r;
    logic phase_r;
    logic pulse_start;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and sampling strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            volt_sync_r <= 2'h0;
            curr_sync_r <= 2'h0;
        end else begin
            volt_sync_r <= {volt_sync_r[0], sd_volt_i};
            curr_sync_r <= {curr_sync_r[0], sd_curr_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_r <= 2'h0;
            samp_en_r <= 1'b0;
            samp_clk_o <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'h1;
            samp_en_r <= (ph_r == SAMP_PH_LAST);
            samp_clk_o <= ph_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decimators
    mflm_decim #(.OUT_W(VOLT_W), .PRE_SHL(VOLT_PRE_SHL), .GAIN_SHR(GAIN_V_SHR)) u_volt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .samp_en_i(samp_en_r),
        .bit_i(volt_sync_r[1]),
        .res_o(volt_res),
        .valid_o(volt_v)
    );

    mflm_decim #(.OUT_W(CURR_W), .PRE_SHL(CURR_PRE_SHL), .GAIN_SHR(GAIN_I_SHR)) u_curr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .samp_en_i(samp_en_r),
        .bit_i(curr_sync_r[1]),
        .res_o(curr_res),
        .valid_o(curr_v)
    );

    ////////////////////////////////////////////////////////////////////////
    // Gain decode
    assign gsel = ctrl_r[CTRL_SEL_LSB+:2];
    assign xg = ctrl_r[CTRL_XG_BIT];
    assign dual = ctrl_r[CTRL_DUAL_BIT];

    always_comb begin
        case (gsel)
            2'h0: gain_nxt = xg ? GAIN_16 : GAIN_8;
            2'h1: gain_nxt = xg ? GAIN_32 : GAIN_24;
            SEL_CT: gain_nxt = GAIN_8;
            SEL_SHUNT: gain_nxt = (dual && !cur_sel_o) ? GAIN_8 : GAIN_32;
            default: gain_nxt = GAIN_8;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pga_gain_o <= GAIN_8;
        end else begin
            pga_gain_o <= gain_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_cnt_r <= '0;
            cur_sel_o <= 1'b0;
            settle_r <= 1'b0;
        end else if (!dual) begin
            mux_cnt_r <= '0;
            cur_sel_o <= 1'b0;
            settle_r <= 1'b0;
        end else if (curr_v) begin
            settle_r <= 1'b0;
            mux_cnt_r <= mux_cnt_r + 1'b1;
            if (mux_cnt_r == ($clog2(MUX_OUTPUTS))'(MUX_OUTPUTS - 1)) begin
                mux_cnt_r <= '0;
                cur_sel_o <= ~cur_sel_o;
                settle_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // positive peak pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vprev_r <= '0;
            rising_r <= 1'b0;
            peak_r <= 1'b0;
            peak_q_r <= 1'b0;
        end else begin
            peak_q_r <= peak_r;
            peak_r <= volt_v && rising_r && (volt_res < vprev_r) && (vprev_r > 0);
            if (volt_v) begin
                vprev_r <= volt_res;
                rising_r <= volt_res > vprev_r;
            end
        end
    end

    assign trail = peak_q_r && !peak_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_cnt_r <= '0;
            per_last_r <= '0;
        end else if (trail) begin
            per_last_r <= per_cnt_r;
            per_cnt_r <= PER_W'(1);
        end else if (per_cnt_r <= PER_W'(PER_LONG)) begin
            per_cnt_r <= per_cnt_r + PER_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_err_r <= 1'b0;
        end else if (per_cnt_r > PER_W'(PER_LONG)) begin
            low_err_r <= 1'b1;
        end else if (trail) begin
            low_err_r <= 1'b0;
        end
    end

    // three short periods in a row
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_run_r <= 2'h0;
            high_err_r <= 1'b0;
        end else if (trail) begin
            if (per_cnt_r < PER_W'(PER_SHORT)) begin
                if (short_run_r != SHORT_REPEAT) begin
                    short_run_r <= short_run_r + 2'h1;
                end
                high_err_r <= short_run_r >= (SHORT_REPEAT - 2'h1);
            end else begin
                short_run_r <= 2'h0;
                high_err_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line level: peak per period scaled by calibrator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vpk_run_r <= '0;
            vpk_r <= '0;
        end else if (trail) begin
            vpk_r <= vpk_run_r;
            vpk_run_r <= '0;
        end else if (volt_v && !volt_res[VOLT_W-1] && (volt_res[VOLT_W-2:0] > vpk_run_r)) begin
            vpk_run_r <= volt_res[VOLT_W-2:0];
        end
    end

    assign rms_prod = 22'(vpk_r) * 22'(kv_r);
    assign rms_thr = (gsel >= SEL_CT) ? RMS_ON_CT : RMS_ON_ROGO;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rms_err_r <= 1'b0;
        end else if (trail) begin
            if (rms_prod < rms_thr) begin
                rms_err_r <= 1'b1;
            end else if (rms_prod > (rms_thr << 1)) begin
                rms_err_r <= 1'b0;
            end
        end
    end

    assign bfr_nxt = low_err_r || high_err_r || rms_err_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bfr_q_r <= 1'b0;
            base_freq_range_error_o <= 1'b0;
        end else begin
            bfr_q_r <= bfr_nxt;
            base_freq_range_error_o <= bfr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Energy accumulation and output pulses
    assign pacc_sum = pacc_r + 32'(volt_res * curr_res);
    assign pulse_start = curr_v && !settle_r && (pacc_sum >= $signed(PULSE_THR));

    always_ff @(posedge clk_i) begin
        if (rst_i || bfr_nxt) begin
            pacc_r <= '0;
        end else if (curr_v && !settle_r) begin
            if (pulse_start) begin
                pacc_r <= pacc_sum - $signed(PULSE_THR);
            end else if (pacc_sum < 0) begin
                pacc_r <= '0;
            end else begin
                pacc_r <= pacc_sum;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || bfr_nxt) begin
            pulse_cnt_r <= 8'h00;
            phase_r <= 1'b0;
            pulse_o <= 1'b0;
            stepper_drive_pos_o <= 1'b0;
            stepper_drive_neg_o <= 1'b0;
        end else if (pulse_start) begin
            pulse_cnt_r <= PULSE_CYC;
            phase_r <= ~phase_r;
            pulse_o <= 1'b1;
            stepper_drive_pos_o <= !phase_r;
            stepper_drive_neg_o <= phase_r;
        end else if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
            if (pulse_cnt_r == 8'h01) begin
                pulse_o <= 1'b0;
                stepper_drive_pos_o <= 1'b0;
                stepper_drive_neg_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b+:8] = {8{wb_sel_i[b]}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rdata;
        end
    end

    always_comb begin
        case (wb_adr_i)
            ADR_CTRL: rdata = 32'(ctrl_r);
            ADR_KV: rdata = 32'(kv_r);
            ADR_STAT: rdata = 32'(stat_r);
            ADR_MASK: rdata = 32'(mask_r);
            ADR_LIVE: rdata = {16'h0000, 2'h0, pga_gain_o, 3'h0, cur_sel_o,
                               rms_err_r, high_err_r, low_err_r, bfr_q_r};
            ADR_VOLT: rdata = 32'(volt_res);
            ADR_CURR: rdata = 32'(curr_res);
            ADR_PER: rdata = 32'(per_last_r);
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            mask_r <= MASK_RST;
        end else if (wr_stb && wb_adr_i == ADR_CTRL) begin
            ctrl_r <= (ctrl_r & ~wmask[CTRL_W-1:0]) | (wb_dat_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        end else if (wr_stb && wb_adr_i == ADR_MASK) begin
            mask_r <= (mask_r & ~wmask[IRQ_W-1:0]) | (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kv_r <= KV_RST;
        end else if (wr_stb && wb_adr_i == ADR_KV && wb_sel_i[0] && wb_sel_i[1]) begin
            if (wb_dat_i[KV_W-1:0] < KV_MIN) begin
                kv_r <= KV_MIN;
            end else if (wb_dat_i[KV_W-1:0] > KV_MAX) begin
                kv_r <= KV_MAX;
            end else begin
                kv_r <= wb_dat_i[KV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over clear
    assign ev[IRQ_BFR_SET] = bfr_nxt && !bfr_q_r;
    assign ev[IRQ_BFR_CLR] = !bfr_nxt && bfr_q_r;
    assign ev[IRQ_RESULT] = curr_v;
    assign ev[IRQ_PULSE] = pulse_start && !bfr_nxt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else if (wr_stb && wb_adr_i == ADR_STAT) begin
            stat_r <= (stat_r & ~(wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0])) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_r & mask_r);
        end
    end

endmodule

/* tb/mflm_asserts.sv */
// Port-level assertions of the line monitor
`timescale 1ns/1ps
module mflm_asserts
    import mflm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic samp_clk_o,
    input wire logic cur_sel_o,
    input wire logic [5:0] pga_gain_o,
    input wire logic base_freq_range_error_o,
    input wire logic stepper_drive_pos_o,
    input wire logic stepper_drive_neg_o,
    input wire logic pulse_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr, sel3;
    logic [3:0] ctrl_r, mask_r;
    logic [1:0] age_r;
    logic [5:0] gain_exp;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign sel3 = ctrl_r[3] && ctrl_r[1:0] == SEL_SHUNT && age_r == 2'h3;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of control and mask writes, age since last control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            mask_r <= MASK_RST;
            age_r <= 2'h0;
        end else begin
            if (wr && wb_adr_i == ADR_CTRL) begin
                ctrl_r <= wb_dat_i[3:0];
            end
            if (wr && wb_adr_i == ADR_MASK) begin
                mask_r <= wb_dat_i[3:0];
            end
            age_r <= (wr && wb_adr_i == ADR_CTRL) ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
        end
    end
    always_comb begin
        case (ctrl_r[1:0])
            2'h0: gain_exp = ctrl_r[2] ? GAIN_16 : GAIN_8;
            2'h1: gain_exp = ctrl_r[2] ? GAIN_32 : GAIN_24;
            2'h2: gain_exp = GAIN_8;
            default: gain_exp = GAIN_32;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    a_samp_quarter: assert property ($rose(samp_clk_o) |=> samp_clk_o ##1 (!samp_clk_o) [*2] ##1 samp_clk_o)
        else $error("sampling clock rate wrong");
    a_err_quiet: assert property (base_freq_range_error_o |-> !(stepper_drive_pos_o || stepper_drive_neg_o || pulse_o))
        else $error("outputs active during range error");
    a_gain_decode: assert property (age_r == 2'h3 && !sel3 |-> pga_gain_o == gain_exp)
        else $error("current gain decode wrong");
    a_dual_primary: assert property ((sel3 && !cur_sel_o) [*3] |-> pga_gain_o == GAIN_8)
        else $error("primary gain wrong");
    a_dual_second: assert property ((sel3 && cur_sel_o) [*3] |-> pga_gain_o == GAIN_32)
        else $error("secondary gain wrong");
    a_single_path: assert property (age_r == 2'h3 && !ctrl_r[3] |-> !cur_sel_o)
        else $error("secondary selected in single mode");
    a_irq_masked: assert property (mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq_o)
        else $error("interrupt while fully masked");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acked");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule

/* tb/mflm_sd_model.sv */
// Behavioural sigma-delta modulators of line voltage and current
`timescale 1ns/1ps
module mflm_sd_model #(
    parameter int LINE_CYC = 12288,
    parameter real AMP_V = 0.5,
    parameter real AMP_I = 0.25
) (
    input wire logic samp_clk_i,
    input wire logic mute_i,
    output logic sd_volt_o,
    output logic sd_curr_o
);
    real acc_v = 0.0;
    real acc_i = 0.0;
    real x;
    int n = 0;
    initial begin
        sd_volt_o = 1'b0;
        sd_curr_o = 1'b0;
    end
    always @(posedge samp_clk_i) begin
        x = mute_i ? 0.0 : $sin(6.2831853 * 4.0 * n / LINE_CYC);
        n = n + 1;
        acc_v = acc_v + AMP_V * x - (sd_volt_o ? 1.0 : -1.0);
        acc_i = acc_i + AMP_I * x - (sd_curr_o ? 1.0 : -1.0);
        sd_volt_o <= acc_v >= 0.0;
        sd_curr_o <= acc_i >= 0.0;
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench of the line monitor
`timescale 1ns/1ps
module testbench
    import mflm_pkg::*;
;
    localparam int LONG_N = 30000;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mute_r, sd_volt_i, sd_curr_i;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic samp_clk_o, cur_sel_o, base_freq_range_error_o, irq_o, stepper_drive_pos_o, stepper_drive_neg_o, pulse_o;
    logic [5:0] pga_gain_o;
    logic [5:0] gtab [8] = '{GAIN_8, GAIN_24, GAIN_8, GAIN_32, GAIN_16, GAIN_32, GAIN_8, GAIN_32};
    int err_total, tests_run, cyc_n;

    mflm_top #(.PER_LONG(LONG_N), .PER_SHORT(4096), .MUX_OUTPUTS(4)) dut_u (.*);
    mflm_sd_model #(.AMP_I(0.5)) line_u (.samp_clk_i(samp_clk_o), .mute_i(mute_r),
        .sd_volt_o(sd_volt_i), .sd_curr_o(sd_curr_i));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 16);
        rd = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            conclude();
        end
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, adr, 32'h0, v);
        check(nm, v, exp);
    endtask
    task automatic wait_on(input bit which, input logic v, input int lim);
        int k;
        k = 0;
        while ((which ? cur_sel_o : base_freq_range_error_o) !== v && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= lim) begin
            err_total++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc_n <= rst_i ? 0 : cyc_n + 1;

    initial begin
        {err_total, tests_run} = '0;
        {rst_i, mute_r, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {2'h3, 3'h0, 8'h00, 4'h0, 32'h0};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl", ADR_CTRL, 32'(CTRL_RST));
        rd_chk("kv", ADR_KV, 32'(KV_RST));
        rd_chk("mask", ADR_MASK, 32'(MASK_RST));
        wb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF, d);
        rd_chk("unmapped", 8'h20, 32'h0);
        wb_xfer(1'b1, ADR_KV, 32'h0, d);
        rd_chk("kv_low", ADR_KV, 32'(KV_MIN));
        wb_xfer(1'b1, ADR_KV, 32'h7FF, d);
        rd_chk("kv_high", ADR_KV, 32'(KV_MAX));
        wb_xfer(1'b1, ADR_KV, 32'h3C0, d);
        rd_chk("kv_mid", ADR_KV, 32'h3C0);
        wb_xfer(1'b1, ADR_KV, 32'(KV_RST), d);
        for (int c = 0; c < 8; c++) begin
            wb_xfer(1'b1, ADR_CTRL, 32'(c), d);
            repeat (3) @(posedge clk_i);
            check("gain", 32'(pga_gain_o), 32'(gtab[c]));
            check("cur_sel", 32'(cur_sel_o), 32'h0);
        end
        wb_xfer(1'b1, ADR_CTRL, 32'h9, d);
        repeat (3) @(posedge clk_i);
        check("dual_gain", 32'(pga_gain_o), 32'(GAIN_24));
        wb_xfer(1'b1, ADR_CTRL, 32'hB, d);
        for (int s = 1; s >= 0; s--) begin
            wait_on(1'b1, s[0], 12000);
            repeat (3) @(posedge clk_i);
            check("dual_sel3", 32'(pga_gain_o), s ? 32'(GAIN_32) : 32'(GAIN_8));
        end
        wb_xfer(1'b1, ADR_CTRL, 32'h0, d);
        // Silent line: no peaks, counting stalls
        wait_on(1'b0, 1'b1, 40000);
        check("stall_time", 32'(cyc_n > LONG_N && cyc_n < LONG_N + 64), 32'h1);
        repeat (2) @(posedge clk_i);
        check("quiet_out", {29'h0, stepper_drive_pos_o, stepper_drive_neg_o, pulse_o}, 32'h0);
        wb_xfer(1'b0, ADR_STAT, 32'h0, d);
        check("stat_set", 32'(d[0]), 32'h1);
        wb_xfer(1'b1, ADR_MASK, 32'h1, d);
        repeat (3) @(posedge clk_i);
        check("irq_on", 32'(irq_o), 32'h1);
        wb_xfer(1'b1, ADR_MASK, 32'h0, d);
        repeat (3) @(posedge clk_i);
        check("irq_masked", 32'(irq_o), 32'h0);
        wb_xfer(1'b1, ADR_MASK, 32'h1, d);
        wb_xfer(1'b1, ADR_STAT, 32'h1, d);
        repeat (3) @(posedge clk_i);
        check("irq_clear", 32'(irq_o), 32'h0);
        // Live in-band line recovers
        wb_xfer(1'b1, ADR_MASK, 32'h2, d);
        mute_r <= 1'b0;
        wait_on(1'b0, 1'b0, 60000);
        repeat (3) @(posedge clk_i);
        check("irq_recover", 32'(irq_o), 32'h1);
        // Energy flows again once the error is gone
        for (int k = 0; k < 30000 && pulse_o !== 1'b1; k++) begin
            @(posedge clk_i);
        end
        check("pulse_on", {stepper_drive_pos_o, stepper_drive_neg_o, pulse_o}, 32'h5);
        rd_chk("period", ADR_PER, 32'h3000);
        conclude();
    end
endmodule

bind mflm_top mflm_asserts chk_u (.*);
